// ---- logic/eptb_pkg.sv ----
// Package for the EEPROM program time base controller: register map, fields and timing constants.
`default_nettype none
package eptb_pkg;
    localparam logic [11:0] REG_PROG_CTRL   = 12'h000;
    localparam logic [11:0] REG_DIV_HIGH    = 12'h004;
    localparam logic [11:0] REG_DIV_LOW     = 12'h008;
    localparam logic [11:0] REG_IRQ_STATUS  = 12'h00C;
    localparam logic [11:0] REG_IRQ_MASK    = 12'h010;
    localparam logic [11:0] REG_OP_STATUS   = 12'h014;
    localparam int          DIV_W           = 10;
    localparam int          DIV_HIGH_W      = 2;
    localparam int          DIV_LOW_W       = 8;
    localparam int          BIT_PGM         = 0;
    localparam int          BIT_ERASE       = 2;
    localparam int          BIT_AUTO        = 5;
    localparam logic [7:0]  PROG_CTRL_MASK  = 8'h25;
    localparam logic [7:0]  PROG_CTRL_RESET = 8'h00;
    localparam logic [DIV_W-1:0] DIV_ONE    = 10'h001;
    localparam int          TICKS_W         = 16;
    localparam logic [TICKS_W-1:0] PROG_TICKS_DEF  = 16'h0028;
    localparam logic [TICKS_W-1:0] ERASE_TICKS_DEF = 16'h0028;
    localparam logic [TICKS_W-1:0] TICKS_ONE       = 16'h0001;
    localparam int          IRQ_W           = 2;
    localparam int          IRQ_DONE        = 0;
    localparam int          IRQ_ABORT       = 1;
    typedef struct packed {
        logic [DIV_HIGH_W-1:0] high;
        logic [DIV_LOW_W-1:0]  low;
    } eptb_div_t;
    typedef struct packed {
        logic active;
        logic erase;
        logic tick;
    } eptb_nvm_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_AUTO = 3'b010,
        ST_MAN  = 3'b100
    } eptb_state_t;
endpackage : eptb_pkg
`default_nettype wire

// ---- logic/eptb_ctrl.sv ----
// EEPROM program and erase time base controller with APB register access.
`default_nettype none
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RULE1) Time base counts edges of the external clock input, not the bus clock.
// (RULE2) Ten-bit divide ratio split over high and low registers divides the external clock.
// (RULE3) Divider registers are volatile and reload from the shadow word on every reset.
// (RULE4) Program control register holds the automatic timing enable at bit five.
// (RULE5) In automatic mode the device times each program or erase operation itself.
// (RULE6) In automatic mode the device clears the program pulse bit when done.
// (RULE7) Software may write a location up to eight times before one erase; the controller neither counts nor limits writes per location.
// (RULE8) In manual mode the operation lasts while software holds the pulse bit.
module eptb_ctrl
    import eptb_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    input  wire logic                 external_clock_input,
    input  wire logic [DIV_W-1:0]     shadow_divider,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      irq,
    output eptb_nvm_t                 nvm_ctrl
);
    ////////////////////////////////////////////////////////////////////////////////////////////////
    logic        ext_s1_q, ext_s2_q, ext_s3_q;
    logic        ext_rise;
    eptb_div_t   div_q;
    logic [DIV_W-1:0]   div_ratio;
    logic [DIV_W-1:0]   pre_cnt_q;
    logic        tick_q;
    logic [7:0]  prog_ctrl_q;
    logic [TICKS_W-1:0] op_cnt_q;
    eptb_state_t state_q;
    logic [IRQ_W-1:0]   irq_stat_q, irq_mask_q, irq_set;
    logic        wr_acc, rd_acc, addr_ok;
    logic        auto_done;
    logic        wr_prog, wr_div_h, wr_div_l;

    assign wr_acc    = psel && penable && pwrite && pready;
    assign rd_acc    = psel && penable && !pwrite && pready;
    assign wr_prog   = wr_acc && (paddr == REG_PROG_CTRL);
    assign wr_div_h  = wr_acc && (paddr == REG_DIV_HIGH);
    assign wr_div_l  = wr_acc && (paddr == REG_DIV_LOW);
    assign div_ratio = {div_q.high, div_q.low};
    assign ext_rise  = ext_s2_q && !ext_s3_q; // RULE1

    always_comb begin
        if (paddr == REG_PROG_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr == REG_DIV_HIGH || paddr == REG_DIV_LOW) begin
            addr_ok = 1'b1;
        end else if (paddr == REG_IRQ_STATUS || paddr == REG_IRQ_MASK || paddr == REG_OP_STATUS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // The external clock is far slower than mclk, so it is sampled and its rising edges counted.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else if (clk_en) begin
            ext_s1_q <= external_clock_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Synchronous reset lets the shadow word be taken as a plain clocked load.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            div_q <= eptb_div_t'(shadow_divider); // RULE3
        end else if (clk_en) begin
            if (wr_div_h) begin
                div_q.high <= pwdata[DIV_HIGH_W-1:0]; // RULE2
            end
            if (wr_div_l) begin
                div_q.low <= pwdata[DIV_LOW_W-1:0]; // RULE2
            end
        end
    end

    // A ratio of zero is treated as one so the time base never stops.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pre_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else if (clk_en) begin
            tick_q <= 1'b0;
            if (ext_rise) begin
                if (pre_cnt_q + DIV_ONE >= div_ratio) begin // RULE2
                    pre_cnt_q <= '0;
                    tick_q    <= 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + DIV_ONE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    assign auto_done = (state_q == ST_AUTO) && tick_q && (op_cnt_q == TICKS_ONE);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q  <= ST_IDLE;
            op_cnt_q <= '0;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: begin
                    if (prog_ctrl_q[BIT_PGM] && prog_ctrl_q[BIT_AUTO]) begin
                        state_q  <= ST_AUTO; // RULE5
                        op_cnt_q <= prog_ctrl_q[BIT_ERASE] ? ERASE_TICKS_DEF : PROG_TICKS_DEF;
                    end else if (prog_ctrl_q[BIT_PGM]) begin
                        state_q <= ST_MAN;
                    end
                end
                ST_AUTO: begin
                    if (!prog_ctrl_q[BIT_PGM]) begin
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        op_cnt_q <= op_cnt_q - TICKS_ONE; // RULE5
                    end
                end
                ST_MAN: begin
                    if (!prog_ctrl_q[BIT_PGM]) begin
                        state_q <= ST_IDLE; // RULE8
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Software may not flip auto or erase mid-operation; only the pulse bit is writable then.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prog_ctrl_q <= PROG_CTRL_RESET;
        end else if (clk_en) begin
            if (auto_done) begin
                prog_ctrl_q[BIT_PGM] <= 1'b0; // RULE6
            end else if (wr_prog && state_q != ST_IDLE) begin
                prog_ctrl_q[BIT_PGM] <= pwdata[BIT_PGM]; // RULE8
            end else if (wr_prog) begin
                prog_ctrl_q <= pwdata[7:0] & PROG_CTRL_MASK; // RULE4
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            nvm_ctrl <= '0;
        end else if (clk_en) begin
            nvm_ctrl.active <= (state_q != ST_IDLE) && prog_ctrl_q[BIT_PGM] && !auto_done; // RULE8
            nvm_ctrl.erase  <= prog_ctrl_q[BIT_ERASE];
            nvm_ctrl.tick   <= tick_q; // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    assign irq_set[IRQ_DONE]  = auto_done;
    assign irq_set[IRQ_ABORT] = (state_q == ST_AUTO) && wr_prog && !pwdata[BIT_PGM] && !auto_done;

    // A new event in the same cycle as the clearing read survives.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq        <= 1'b0;
        end else if (clk_en) begin
            if (rd_acc && paddr == REG_IRQ_STATUS) begin
                irq_stat_q <= irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (wr_acc && paddr == REG_IRQ_MASK) begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
            irq <= |((irq_stat_q | irq_set) & irq_mask_q
                     & ~((rd_acc && paddr == REG_IRQ_STATUS) ? irq_stat_q : '0));
        end
    end

    // Zero wait states: pready rises in the access phase, one cycle after setup.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                if (paddr == REG_PROG_CTRL) begin
                    prdata[7:0] <= prog_ctrl_q;
                end else if (paddr == REG_DIV_HIGH) begin
                    prdata[DIV_HIGH_W-1:0] <= div_q.high;
                end else if (paddr == REG_DIV_LOW) begin
                    prdata[DIV_LOW_W-1:0] <= div_q.low;
                end else if (paddr == REG_IRQ_STATUS) begin
                    prdata[IRQ_W-1:0] <= irq_stat_q;
                end else if (paddr == REG_IRQ_MASK) begin
                    prdata[IRQ_W-1:0] <= irq_mask_q;
                end else if (paddr == REG_OP_STATUS) begin
                    prdata[2:0] <= state_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    a_auto_clear_pgm: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
        clk_en && auto_done |=> !prog_ctrl_q[BIT_PGM])
        else $error("Auto completion did not clear the pulse bit.");
    a_manual_holds_pgm: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
        state_q == ST_MAN && prog_ctrl_q[BIT_PGM] && !wr_prog |=> prog_ctrl_q[BIT_PGM])
        else $error("Manual mode cleared the pulse bit by itself.");
    a_tick_needs_edge: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
        clk_en && tick_q |-> $past(ext_rise))
        else $error("Time base tick without an external clock edge.");
    a_div_reload: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
        $rose(resetn) |-> div_ratio == $past(shadow_divider))
        else $error("Divider not loaded from the shadow word.");
    a_auto_bit_five: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
        clk_en && wr_prog && state_q == ST_IDLE && !auto_done |=> prog_ctrl_q[BIT_AUTO] == $past(pwdata[BIT_AUTO]))
        else $error("Automatic enable not stored at bit five.");
    a_auto_loads_time: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
        clk_en && state_q == ST_IDLE && prog_ctrl_q[BIT_PGM] && prog_ctrl_q[BIT_AUTO]
        |=> state_q == ST_AUTO && op_cnt_q != '0)
        else $error("Automatic operation did not start its timer.");
    a_div_write_high: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
        clk_en && wr_div_h |=> div_q.high == $past(pwdata[DIV_HIGH_W-1:0]))
        else $error("High divider write lost.");
    a_active_output: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
        clk_en && state_q == ST_MAN && prog_ctrl_q[BIT_PGM] |=> nvm_ctrl.active)
        else $error("Operation not active while pulse bit held.");
    // Checks below pin down the timer, the locked mode bits and the strobes seen by the array.
    a_tick_one_cycle: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
        clk_en && tick_q |=> !tick_q)
        else $error("Time base tick lasted more than one cycle.");
    a_nvm_tick_follows: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
        clk_en && tick_q |=> nvm_ctrl.tick)
        else $error("Time base tick not passed to the array.");
    a_div_write_low: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
        clk_en && wr_div_l |=> div_q.low == $past(pwdata[DIV_LOW_W-1:0]))
        else $error("Low divider write lost.");
    a_prescale_wrap: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
        clk_en && ext_rise && (pre_cnt_q + DIV_ONE >= div_ratio) |=> pre_cnt_q == '0 && tick_q)
        else $error("Prescaler did not wrap at the divide ratio.");
    a_div_holds: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
        clk_en && !wr_div_h && !wr_div_l |=> div_ratio == $past(div_ratio))
        else $error("Divider changed without a write.");
    a_unused_bits_zero: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
        (prog_ctrl_q & ~PROG_CTRL_MASK) == 8'h00)
        else $error("Unused program control bit set.");
    a_auto_mode_locked: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
        clk_en && state_q != ST_IDLE |=> prog_ctrl_q[BIT_AUTO] == $past(prog_ctrl_q[BIT_AUTO]))
        else $error("Automatic enable changed during an operation.");
    a_erase_locked: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
        clk_en && state_q != ST_IDLE |=> prog_ctrl_q[BIT_ERASE] == $past(prog_ctrl_q[BIT_ERASE]))
        else $error("Erase select changed during an operation.");
    a_erase_follows: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
        clk_en |=> nvm_ctrl.erase == $past(prog_ctrl_q[BIT_ERASE]))
        else $error("Erase strobe does not follow the erase select.");
    a_auto_counts_ticks: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
        clk_en && state_q == ST_AUTO && prog_ctrl_q[BIT_PGM] && tick_q |=> op_cnt_q == $past(op_cnt_q) - TICKS_ONE)
        else $error("Automatic timer did not count a tick.");
    a_auto_holds_count: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
        clk_en && state_q == ST_AUTO && !tick_q |=> op_cnt_q == $past(op_cnt_q))
        else $error("Automatic timer moved without a tick.");
    a_auto_done_once: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
        clk_en && auto_done |=> !auto_done)
        else $error("Automatic completion seen twice.");
    a_auto_done_ends: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
        clk_en && auto_done ##1 clk_en |=> state_q == ST_IDLE)
        else $error("Automatic operation did not return to idle.");
    a_done_sets_flag: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
        clk_en && auto_done |=> irq_stat_q[IRQ_DONE])
        else $error("Completion did not set the status flag.");
    a_idle_inactive: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
        clk_en && state_q == ST_IDLE |=> !nvm_ctrl.active)
        else $error("Array driven while idle.");
    a_manual_stays: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
        clk_en && state_q == ST_MAN && prog_ctrl_q[BIT_PGM] |=> state_q == ST_MAN)
        else $error("Manual operation left while pulse bit held.");
    a_manual_ends: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
        clk_en && state_q == ST_MAN && !prog_ctrl_q[BIT_PGM] |=> state_q == ST_IDLE)
        else $error("Manual operation did not end on pulse bit clear.");
endmodule : eptb_ctrl
`default_nettype wire

// ---- tb/eptb_nvm_model.sv ----
// Behavioural model of the EEPROM array as seen through the time base strobes.
`timescale 1ns/1ns
`default_nettype none
module eptb_nvm_model
    import eptb_pkg::*;
(
    input  wire logic      mclk,
    input  wire eptb_nvm_t ctrl,
    output var int         op_ticks,
    output var int         tick_gap,
    output var int         n_ticks
);
    int   gap_q = 0;
    logic act_q = 1'b0;
    initial begin
        op_ticks = 0;
        tick_gap = 0;
        n_ticks  = 0;
    end
    // Strobe spacing is measured in bus cycles, so a divider fed by the bus clock shows up as a wrong gap.
    always @(posedge mclk) begin
        act_q <= ctrl.active;
        gap_q <= gap_q + 1;
        if (ctrl.tick) begin
            n_ticks  <= n_ticks + 1;
            tick_gap <= gap_q + 1;
            gap_q    <= 0;
        end
        // A pass of cell charge, partial write or erase, only advances on strobes while driven.
        if (ctrl.active && !act_q) begin
            op_ticks <= int'(ctrl.tick);
        end else if (ctrl.active && ctrl.tick) begin
            op_ticks <= op_ticks + 1;
        end
    end
endmodule : eptb_nvm_model
`default_nettype wire

// ---- tb/eptb_ctrl_test.sv ----
// Self-checking testbench of the EEPROM time base controller.
`timescale 1ns/1ns
`default_nettype none
module eptb_ctrl_test
    import eptb_pkg::*;
    ;
    localparam logic [DIV_W-1:0] SHADOW = 10'h2A5;
    logic        mclk = 0, resetn = 0, ext_clk = 0, clk_en = 1;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    eptb_nvm_t   nvm_ctrl;
    int          op_ticks, tick_gap, n_ticks, n_mismatch = 0, comparisons = 0;
    eptb_ctrl u_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .external_clock_input(ext_clk),
        .shadow_divider(SHADOW), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .nvm_ctrl(nvm_ctrl));
    eptb_nvm_model u_nvm (.mclk(mclk), .ctrl(nvm_ctrl), .op_ticks(op_ticks), .tick_gap(tick_gap),
        .n_ticks(n_ticks));
    initial forever #50 mclk = ~mclk;
    // The time base source runs at a tenth of the bus rate, offset so no edge meets a bus edge.
    initial begin
        #37;
        forever #500 ext_clk = ~ext_clk;
    end
    //////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            end_sim();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask : rdc
    task automatic set_ratio(input logic [DIV_W-1:0] r);
        apb(1'b1, REG_DIV_HIGH, {30'h0, r[9:8]});
        apb(1'b1, REG_DIV_LOW, {24'h0, r[7:0]});
    endtask : set_ratio
    //////////////////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(REG_DIV_HIGH, {30'h0, SHADOW[9:8]}, "div_high");
        rdc(REG_DIV_LOW, {24'h0, SHADOW[7:0]}, "div_low");
        rdc(REG_PROG_CTRL, 32'h0, "prog_ctrl");
        rdc(REG_OP_STATUS, 32'h1, "op_status");
        apb(1'b1, REG_DIV_LOW, 32'h11);
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdc(REG_DIV_LOW, {24'h0, SHADOW[7:0]}, "div_low_rst");
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
    endtask : t_reset
    // Strobe spacing is checked while a manual operation runs, so both hold at once.
    task automatic t_manual();
        logic [DIV_W-1:0] r [3] = '{10'h001, 10'h003, 10'h000};
        int               n;
        int               base;
        apb(1'b1, REG_PROG_CTRL, 32'h1);
        foreach (r[i]) begin
            set_ratio(r[i]);
            base = n_ticks;
            n = 0;
            while (n_ticks < base + 3 && n < 200) begin
                @(posedge mclk);
                n++;
            end
            if (n >= 200) begin
                n_mismatch++;
                end_sim();
            end
            chk("tick_gap", tick_gap, ((r[i] == 0) ? 1 : r[i]) * 10);
        end
        chk("manual_active", {31'h0, nvm_ctrl.active}, 32'h1);
        rdc(REG_PROG_CTRL, 32'h1, "manual_pulse");
        rdc(REG_OP_STATUS, 32'h4, "manual_state");
        apb(1'b1, REG_PROG_CTRL, 32'h0);
        repeat (3) @(posedge mclk);
        chk("manual_end", {31'h0, nvm_ctrl.active}, 32'h0);
    endtask : t_manual
    task automatic t_auto();
        int n;
        int exp_t;
        set_ratio(10'h002);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, REG_IRQ_MASK, (i == 0) ? 32'h1 : 32'h0);
            apb(1'b1, REG_PROG_CTRL, (i == 0) ? 32'h21 : 32'h25);
            rdc(REG_OP_STATUS, 32'h2, "auto_state");
            chk("auto_erase", {31'h0, nvm_ctrl.erase}, i);
            n = 0;
            do begin
                apb(1'b0, REG_PROG_CTRL, 32'h0);
                n++;
            end while (rd[BIT_PGM] !== 1'b0 && n < 1000);
            if (n >= 1000) begin
                n_mismatch++;
                end_sim();
            end
            chk("auto_clear", rd, (i == 0) ? 32'h20 : 32'h24);
            exp_t = (i == 0) ? int'(PROG_TICKS_DEF) : int'(ERASE_TICKS_DEF);
            chk("auto_len", {31'h0, op_ticks >= exp_t - 1 && op_ticks <= exp_t + 1}, 32'h1);
            chk("irq_level", {31'h0, irq}, (i == 0) ? 32'h1 : 32'h0);
            rdc(REG_IRQ_STATUS, 32'h1, "irq_status");
            repeat (2) @(posedge mclk);
            chk("irq_cleared", {31'h0, irq}, 32'h0);
            rdc(REG_IRQ_STATUS, 32'h0, "irq_read_clear");
        end
    endtask : t_auto
    //////////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_manual();
        t_auto();
        end_sim();
    end
endmodule : eptb_ctrl_test
`default_nettype wire
